/* File: src/vdtc_cfg.svh */
// Constants for the video DRAM display transfer controller
`ifndef VDTC_CFG_SVH
`define VDTC_CFG_SVH
`define VDTC_CLK_MHZ 125
`define VDTC_WORD_W 16
`define VDTC_NIBBLE_W 4
`define VDTC_DEVICES 4
`define VDTC_ROW_BITS 256
`define VDTC_ROW_LAST 8'hff
`define VDTC_PIXELS_PER_XFER (`VDTC_WORD_W * `VDTC_ROW_BITS)
`define VDTC_ADDR_W 16
`define VDTC_ROW_STEP 16'h0100
`define VDTC_FIFO_DEPTH 32
`define VDTC_SC_HALF_NS 32
`define VDTC_SC_HALF_CYC ((`VDTC_SC_HALF_NS * `VDTC_CLK_MHZ + 999) / 1000)
`define VDTC_DT_RAS_NS 16
`define VDTC_DT_RAS_CYC ((`VDTC_DT_RAS_NS * `VDTC_CLK_MHZ + 999) / 1000)
`define VDTC_RAS_HOLD_NS 48
`define VDTC_RAS_HOLD_CYC ((`VDTC_RAS_HOLD_NS * `VDTC_CLK_MHZ + 999) / 1000)
`endif

/* File: src/vdtc_fifo.sv */
// Serial word FIFO between the video DRAM serial port and the output register
`timescale 1ns/1ps
`default_nettype none
module vdtc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  vdtc_stream_if.snk wr,
  vdtc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_wr = clk_en && wr.valid && wr.ready;
  wire do_rd = clk_en && rd.valid && rd.ready;
  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data = mem[rd_ptr];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) wr_ptr <= ptr_inc(wr_ptr);
      if (do_rd) rd_ptr <= ptr_inc(rd_ptr);
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  fifo_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule : vdtc_fifo
`default_nettype wire

/* File: src/vdtc_pkg.sv */
// Types for the video DRAM display transfer controller
package vdtc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT_BUS = 6'h02,
    ST_DT_LOW = 6'h04,
    ST_RAS_LOW = 6'h08,
    ST_HOLD = 6'h10,
    ST_DONE = 6'h20
  } vdtc_state_e;
  typedef logic [3:0] vdtc_tmr_t;
endpackage : vdtc_pkg

/* File: src/vdtc_stream_if.sv */
// Valid/ready word stream between the controller and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface vdtc_stream_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : vdtc_stream_if
`default_nettype wire

/* File: src/vdtc_top.sv */
// Display refresh transfer control for a video DRAM frame buffer
`timescale 1ns/1ps
`default_nettype none
`include "vdtc_cfg.svh"
module vdtc_top
  import vdtc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic load_clock,
  input wire logic bus_wait_in,
  input wire logic line_end_in,
  input wire logic [`VDTC_WORD_W-1:0] serial_data_in,
  input wire logic mid_line_mode,
  input wire logic [`VDTC_ADDR_W-1:0] warp,
  input wire logic [7:0] hold_lck_count,
  output logic transfer_output_enable_n,
  output logic row_strobe_n,
  output logic [`VDTC_ADDR_W-1:0] transfer_addr,
  output logic display_refresh_request,
  output logic wait_release,
  output logic serial_shift_clock,
  output logic [`VDTC_WORD_W-1:0] pixel_word,
  output logic pixel_word_strobe,
  output logic underrun
);
  vdtc_state_e state;
  vdtc_state_e next_state;
  vdtc_tmr_t tmr;
  logic [2:0] lck_sync;
  logic [1:0] wait_sync;
  logic [2:0] line_sync;
  logic [`VDTC_WORD_W-1:0] data_s1;
  logic [`VDTC_WORD_W-1:0] data_s2;
  logic [7:0] word_cnt;
  logic row_empty;
  logic req_line;
  logic [7:0] hold_cnt;
  logic [3:0] sc_div;
  logic [`VDTC_ADDR_W-1:0] line_base;
  logic [`VDTC_ADDR_W-1:0] row_addr;

  vdtc_stream_if #(.WIDTH(`VDTC_WORD_W)) fifo_in ();
  vdtc_stream_if #(.WIDTH(`VDTC_WORD_W)) fifo_out ();

  vdtc_fifo #(.WIDTH(`VDTC_WORD_W), .DEPTH(`VDTC_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .wr(fifo_in.snk),
    .rd(fifo_out.src)
  );

  function automatic logic [`VDTC_ADDR_W-1:0] addr_add(
    input logic [`VDTC_ADDR_W-1:0] a, input logic [`VDTC_ADDR_W-1:0] b);
    addr_add = `VDTC_ADDR_W'(a + b);
  endfunction : addr_add

  wire lck_rise = lck_sync[1] && !lck_sync[2];
  wire line_end = line_sync[1] && !line_sync[2];
  wire bus_free = wait_sync[1];
  wire sc_tick = (sc_div == 4'(`VDTC_SC_HALF_CYC - 1));
  // Shift clock stalls on a full FIFO, an exhausted row and while a new row settles
  wire sc_run = fifo_in.ready && !row_empty && (state != ST_DONE);
  wire sc_fall = sc_tick && serial_shift_clock;
  wire push = sc_fall && sc_run;
  // One row of 256 words per transfer
  wire last_word = push && (word_cnt == `VDTC_ROW_LAST);
  // Request on counter at 255 in mid-line mode, or on line end
  wire req_event = (mid_line_mode && push && (word_cnt == (`VDTC_ROW_LAST - 8'h01)))
                   || line_end;
  wire accept = (state == ST_WAIT_BUS) && bus_free;
  // Release only while shift clock low, row drained or line request pending, counter done
  // No shift clock rise may share the edge on which the strobe rises
  wire release_ok = (state == ST_HOLD) && (hold_cnt == 8'h00) && !serial_shift_clock
                    && !sc_tick && (row_empty || req_line);
  // Line start adds warp, mid-line continues with next row
  wire [`VDTC_ADDR_W-1:0] next_addr = req_line ? addr_add(line_base, warp)
                                               : addr_add(row_addr, `VDTC_ROW_STEP);
  wire tmr_done = (tmr == '0);
  wire xfer_end = (state == ST_DONE) && tmr_done;

  assign fifo_in.data = data_s2;
  assign fifo_in.valid = push;
  assign fifo_out.ready = lck_rise;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lck_sync <= '0;
      wait_sync <= '0;
      line_sync <= '0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else if (clk_en) begin
      lck_sync <= {lck_sync[1:0], load_clock};
      wait_sync <= {wait_sync[0], bus_wait_in};
      line_sync <= {line_sync[1:0], line_end_in};
      data_s1 <= serial_data_in;
      data_s2 <= data_s1;
    end
  end

  // Serial words delivered one per shift clock
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sc_div <= '0;
      serial_shift_clock <= 1'b0;
    end else if (clk_en) begin
      sc_div <= sc_tick ? 4'h0 : sc_div + 4'h1;
      if (sc_tick) serial_shift_clock <= serial_shift_clock ? 1'b0 : sc_run;
    end
  end

  // Row of 256 words per transfer, then shifting stops
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_cnt <= '0;
      row_empty <= 1'b1;
    end else if (clk_en) begin
      if (state == ST_DONE && tmr_done) begin
        word_cnt <= '0;
        row_empty <= 1'b0;
      end else if (push) begin
        word_cnt <= word_cnt + 8'h01;
        if (last_word) row_empty <= 1'b1;
      end
    end
  end

  // Four nibble-wide devices form one 16-bit word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pixel_word <= '0;
      pixel_word_strobe <= 1'b0;
      underrun <= 1'b0;
    end else if (clk_en) begin
      pixel_word_strobe <= lck_rise && fifo_out.valid;
      if (lck_rise && fifo_out.valid) pixel_word <= fifo_out.data;
      underrun <= lck_rise && !fifo_out.valid;
    end
  end

  // Request flag, a new event beats the clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      display_refresh_request <= 1'b0;
      req_line <= 1'b0;
    end else if (clk_en) begin
      if (req_event) begin
        display_refresh_request <= 1'b1;
        req_line <= line_end || (req_line && !xfer_end);
      end else if (state == ST_DONE && tmr_done) begin
        display_refresh_request <= 1'b0;
        req_line <= 1'b0;
      end
    end
  end

  // Down counter on load clock, started by the request
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt <= '0;
    end else if (clk_en) begin
      if (req_event && (state == ST_IDLE || xfer_end)) hold_cnt <= hold_lck_count;
      else if (lck_rise && hold_cnt != 8'h00) hold_cnt <= hold_cnt - 8'h01;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (display_refresh_request) next_state = ST_WAIT_BUS;
      ST_WAIT_BUS: if (bus_free) next_state = ST_DT_LOW;
      ST_DT_LOW: if (tmr_done) next_state = ST_RAS_LOW;
      ST_RAS_LOW: next_state = ST_HOLD;
      ST_HOLD: if (release_ok) next_state = ST_DONE;
      ST_DONE: if (tmr_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      tmr <= '0;
    end else if (clk_en) begin
      state <= next_state;
      if (accept) tmr <= vdtc_tmr_t'(`VDTC_DT_RAS_CYC - 1);
      else if (release_ok) tmr <= vdtc_tmr_t'(`VDTC_RAS_HOLD_CYC - 1);
      else if (!tmr_done) tmr <= tmr - 4'h1;
    end
  end

  // Transfer strobe falls before the row strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      transfer_output_enable_n <= 1'b1;
      row_strobe_n <= 1'b1;
      wait_release <= 1'b1;
      transfer_addr <= '0;
      line_base <= '0;
      row_addr <= '0;
    end else if (clk_en) begin
      if (accept) begin
        transfer_output_enable_n <= 1'b0;
        wait_release <= 1'b0;
        transfer_addr <= next_addr;
        row_addr <= next_addr;
        if (req_line) line_base <= next_addr;
      end
      if (state == ST_DT_LOW && tmr_done) row_strobe_n <= 1'b0;
      if (release_ok) begin
        transfer_output_enable_n <= 1'b1;
        wait_release <= 1'b1;
      end
      if (state == ST_DONE && tmr_done) row_strobe_n <= 1'b1;
    end
  end

  dt_before_ras_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(row_strobe_n) |-> !transfer_output_enable_n && !$past(transfer_output_enable_n, 2))
    else $error("row strobe fell without transfer strobe low first");
  dt_rise_window_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(transfer_output_enable_n) && !row_strobe_n |-> !serial_shift_clock [*4])
    else $error("shift clock rose too soon after transfer strobe");
  row_stop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    row_empty && !serial_shift_clock |=> !serial_shift_clock)
    else $error("shift clock ran on an exhausted row");
  req_at_255_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && mid_line_mode && push && word_cnt == 8'hfe |=> display_refresh_request)
    else $error("request missing at count 255");
  bus_wait_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(transfer_output_enable_n) |-> $past(bus_free))
    else $error("transfer started while bus busy");
  hold_until_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(wait_release) |-> $past(hold_cnt) == 8'h00 && transfer_output_enable_n)
    else $error("wait released before counter reached zero");
  line_warp_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && accept && req_line |=> line_base == addr_add($past(line_base), $past(warp)))
    else $error("line start address not advanced by warp");
  push_on_fall_a: assert property (@(posedge mclk) disable iff (sys_rst)
    fifo_in.valid |-> serial_shift_clock ##1 !serial_shift_clock)
    else $error("word captured off the shift clock fall");
endmodule : vdtc_top
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the display transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "vdtc_cfg.svh"
module tb;
  logic mclk, sys_rst, clk_en, load_clock, bus_wait_in, line_end_in, mid_line_mode;
  logic [`VDTC_ADDR_W-1:0] warp;
  logic [7:0] hold_lck_count;
  wire logic [`VDTC_WORD_W-1:0] serial_data, pixel_word;
  wire logic [`VDTC_ADDR_W-1:0] transfer_addr;
  wire logic transfer_output_enable_n, row_strobe_n, display_refresh_request;
  wire logic wait_release, serial_shift_clock, pixel_word_strobe, underrun;
  wire logic [8:0] served, served_at_load;
  wire logic [7:0] n_err;
  int n_fail, checks;
  logic px_on;
  logic [15:0] px_prev, px_first;
  int n_under;
  time t_req;
  vdtc_top vdtc_top_inst (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .load_clock(load_clock), .bus_wait_in(bus_wait_in), .line_end_in(line_end_in),
    .serial_data_in(serial_data), .mid_line_mode(mid_line_mode), .warp(warp),
    .hold_lck_count(hold_lck_count), .transfer_output_enable_n(transfer_output_enable_n),
    .row_strobe_n(row_strobe_n), .transfer_addr(transfer_addr),
    .display_refresh_request(display_refresh_request), .wait_release(wait_release),
    .serial_shift_clock(serial_shift_clock), .pixel_word(pixel_word),
    .pixel_word_strobe(pixel_word_strobe), .underrun(underrun));
  vdtc_vram_model vdtc_vram_model_inst (.sys_rst(sys_rst),
    .transfer_output_enable_n(transfer_output_enable_n), .row_strobe_n(row_strobe_n),
    .transfer_addr(transfer_addr), .serial_shift_clock(serial_shift_clock),
    .serial_data(serial_data), .served(served), .served_at_load(served_at_load),
    .n_err(n_err));
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (underrun === 1'b1) n_under <= n_under + 1;
  always @(posedge display_refresh_request) t_req = $time;
  // Load clock offset so its edges sit 1 ns after mclk rising edges, with no drift
  initial begin
    load_clock = 1'b0;
    #5;
    forever #32 load_clock = ~load_clock;
  end
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic sig(input int s);
    case (s)
      0: return transfer_output_enable_n;
      1: return display_refresh_request;
      default: return row_strobe_n;
    endcase
  endfunction : sig
  task automatic step;
    @(posedge mclk);
    #1;
    if (pixel_word_strobe === 1'b1) begin
      if (px_on) check(pixel_word, 16'(px_prev + 16'h1));
      px_on = px_on || (pixel_word === px_first);
      px_prev = pixel_word;
    end
  endtask : step
  // Bounded wait, counts cycles until the level shows
  task automatic wait_lvl(input int s, input logic v, output int n);
    n = 0;
    while (sig(s) !== v && n < 4000) begin
      step;
      n++;
    end
    check(sig(s), v);
  endtask : wait_lvl
  task automatic t_line(output logic [15:0] a);
    int n;
    int span;
    @(posedge mclk);
    bus_wait_in <= 1'b0;
    line_end_in <= 1'b1;
    repeat (4) @(posedge mclk);
    line_end_in <= 1'b0;
    wait_lvl(1, 1'b1, n);
    // Short busy bus, so the hold counter decides the release
    repeat (12) step;
    check(transfer_output_enable_n, 1'b1);
    @(posedge mclk);
    bus_wait_in <= 1'b1;
    wait_lvl(0, 1'b0, n);
    a = transfer_addr;
    check(row_strobe_n, 1'b1);
    check(wait_release, 1'b0);
    wait_lvl(2, 1'b0, n);
    check(n, 2);
    wait_lvl(0, 1'b1, n);
    span = int'(($time - t_req - 1) / 8);
    check(span >= 8 * (hold_lck_count - 1) && span <= 8 * hold_lck_count + 8, 1'b1);
    check(wait_release, 1'b1);
    wait_lvl(1, 1'b0, n);
  endtask : t_line
  task automatic t_reset;
    #1;
    check({transfer_output_enable_n, row_strobe_n}, 2'b11);
    check({serial_shift_clock, display_refresh_request}, 2'b00);
    check(wait_release, 1'b1);
    // No row loaded yet, so every load clock finds the FIFO empty
    repeat (24) step;
    check(n_under > 0 && pixel_word_strobe === 1'b0, 1'b1);
  endtask : t_reset
  task automatic t_lines;
    logic [15:0] a1, a2;
    t_line(a1);
    t_line(a2);
    check(a2 - a1, warp);
  endtask : t_lines
  task automatic t_mid;
    logic [15:0] a;
    int n;
    @(posedge mclk);
    mid_line_mode <= 1'b1;
    t_line(a);
    px_first = a;
    px_on = 1'b0;
    wait_lvl(1, 1'b1, n);
    check(served, 9'd255);
    check(px_on, 1'b1);
    wait_lvl(0, 1'b0, n);
    check(transfer_addr, a + `VDTC_ROW_STEP);
    wait_lvl(0, 1'b1, n);
    check(served_at_load, 9'd256);
    // Words must run on without a gap into the next row
    repeat (400) step;
    px_on = 1'b0;
  endtask : t_mid
  initial begin
    mclk = 1'b0; sys_rst = 1'b1; clk_en = 1'b1; bus_wait_in = 1'b1;
    // Warp of a 2048-pixel line, so a row outlasts each scanline
    line_end_in = 1'b0; mid_line_mode = 1'b0; warp = 16'h0080; hold_lck_count = 8'h04;
    n_fail = 0; checks = 0; px_on = 1'b0; px_prev = '0; px_first = '0; n_under = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_lines;
    t_mid;
    check(n_err, 8'h0);
    finish_test;
  end
  initial begin
    #200000;
    n_fail++;
    $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    finish_test;
  end
endmodule : tb
`default_nettype wire

/* File: verification/vdtc_vram_model.sv */
// Behavioural array of four nibble-wide video DRAMs seen from the serial side
`timescale 1ns/1ps
`default_nettype none
`include "vdtc_cfg.svh"
module vdtc_vram_model (
  input wire logic sys_rst,
  input wire logic transfer_output_enable_n,
  input wire logic row_strobe_n,
  input wire logic [`VDTC_ADDR_W-1:0] transfer_addr,
  input wire logic serial_shift_clock,
  output logic [`VDTC_WORD_W-1:0] serial_data,
  output logic [8:0] served,
  output logic [8:0] served_at_load,
  output logic [7:0] n_err
);
  logic [`VDTC_ADDR_W-1:0] row_base;
  logic [`VDTC_ADDR_W-1:0] latched;
  logic [`VDTC_WORD_W-1:0] word;
  logic xfer;
  initial begin
    serial_data = '0; served = 9'h100; served_at_load = '0; n_err = '0;
    row_base = '0; latched = '0; xfer = 1'b0;
  end
  always @(negedge row_strobe_n) begin
    xfer = !transfer_output_enable_n;
    latched = transfer_addr;
    if (!xfer) n_err = n_err + 8'h1;
  end
  // Whole row loads on strobe rise, shift clock low
  always @(posedge transfer_output_enable_n) begin
    if (xfer && !sys_rst) begin
      if (serial_shift_clock !== 1'b0) n_err = n_err + 8'h1;
      served_at_load = served;
      row_base = latched;
      served = '0;
      xfer = 1'b0;
    end
  end
  // One word per shift clock, four nibbles side by side
  always @(posedge serial_shift_clock) begin
    word = row_base + `VDTC_ADDR_W'(served);
    // Empty register drives junk, the last word inverted, then toggled back on each further shift clock
    if (served >= 9'h100) serial_data = ~serial_data;
    else serial_data = {word[15:12], word[11:8], word[7:4], word[3:0]};
    if (served < 9'h100) served = served + 9'h1;
  end
endmodule : vdtc_vram_model
`default_nettype wire
